// File: design/pasq_pkg.sv
// Purpose: shared constants and types of the converter SPI sequencer
// Assumes: mclk at 10 MHz, link clock sampled as a plain input
// Notes:   command bytes, register defaults and field positions below
`default_nettype none
package pasq_pkg;
    // Command bytes
    localparam logic [7:0] PASQ_CMD_RESET   = 8'h06;
    localparam logic [7:0] PASQ_CMD_START   = 8'h08;
    localparam logic [3:0] PASQ_CMD_WR_HI   = 4'h4;  // config_write_command upper nibble
    // Register defaults after reset
    localparam logic [7:0] PASQ_CFG0_RST    = 8'h00;
    localparam logic [7:0] PASQ_CFG1_RST    = 8'h04;
    localparam logic [7:0] PASQ_CFG2_RST    = 8'h00;
    localparam logic [7:0] PASQ_CFG3_RST    = 8'h00;
    // Register 1 field positions
    localparam int PASQ_RATE_MSB   = 7;
    localparam int PASQ_RATE_LSB   = 5;
    localparam int PASQ_MODE_MSB   = 4;
    localparam int PASQ_MODE_LSB   = 3;
    localparam int PASQ_ONE_BIT    = 2;
    localparam int PASQ_TSEL_BIT   = 1;  // temperature_select_bit
    localparam int PASQ_ZERO_BIT   = 0;
    // Result widths
    localparam int PASQ_TEMP_BITS  = 14;
    localparam int PASQ_RES_BITS   = 24;
    // Conversion time model in microseconds and cycles
    localparam int PASQ_CONV_US    = 20;
    localparam int PASQ_MCLK_MHZ   = 10;
    localparam int PASQ_CONV_CYC   = PASQ_CONV_US * PASQ_MCLK_MHZ;
    // Result word with its kind
    typedef struct packed {
        logic        temp;
        logic [23:0] code;
    } pasq_result_s;
    // Decoder states
    typedef enum logic [2:0] {
        PASQ_IDLE, PASQ_WR_DATA
    } pasq_dec_e;
endpackage : pasq_pkg
`default_nettype wire

// File: design/pasq_buf2.sv
// Purpose: two-entry valid/ready buffer for result words
// Assumes: same clock on both sides
// Notes:   full and empty are exact
`default_nettype none
module pasq_buf2
    import pasq_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // Fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire pasq_result_s  in_data,
    // Drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output pasq_result_s       out_data
);
    pasq_result_s mem_q [2];        // Storage
    pasq_result_s mem_d [2];
    logic         wp_q, wp_d;       // Write index
    logic         rp_q, rp_d;       // Read index
    logic [1:0]   cnt_q, cnt_d;     // Occupancy
    logic         push, pop;

    // Next-state of pointers and storage
    always_comb begin
        push     = in_valid && (cnt_q != 2'h2);
        pop      = (cnt_q != 2'h0) && out_ready;
        mem_d    = mem_q;
        wp_d     = wp_q;
        rp_d     = rp_q;
        cnt_d    = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d        = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    // Registering only
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
endmodule // pasq_buf2
`default_nettype wire

// File: design/pasq_top.sv
// Purpose: converter side of the SPI link: command decode, config, result shift
// Assumes: link clock slow against mclk; host keeps selects exclusive
// Notes:   conversion is modelled as a fixed delay on sample inputs
`default_nettype none
module pasq_top
    import pasq_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // SPI pins from host
    input  wire logic          sclk,
    input  wire logic          adc_select_n,
    input  wire logic          mosi,
    output logic               miso,
    output logic               miso_oe,
    // Analog front end samples
    input  wire logic [13:0]   temp_sample,
    input  wire logic [23:0]   pres_sample,
    // Status and configuration view
    output logic [7:0]         cfg0,
    output logic [7:0]         cfg1,
    output logic [7:0]         cfg2,
    output logic [7:0]         cfg3,
    output logic               converting,
    output logic               result_ready
);
    // Input synchronisers, first stage read only by the second
    logic [2:0] s1_q, s2_q;
    logic       sclk_old_q;
    logic       sclk_s, sel_n_s, mosi_s, rise, fall;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q       <= 3'h2;                 // Idle levels: clock low, select high
            s2_q       <= 3'h2;                 // No false clock edge after reset
            sclk_old_q <= 1'b0;
        end else begin
            s1_q       <= {sclk, adc_select_n, mosi};
            s2_q       <= s1_q;
            sclk_old_q <= s2_q[2];
        end
    end

    // Edge detection on synchronised link clock
    always_comb begin
        sclk_s  = s2_q[2];
        sel_n_s = s2_q[1];
        mosi_s  = s2_q[0];
        rise    = sclk_s && !sclk_old_q && !sel_n_s;
        fall    = !sclk_s && sclk_old_q && !sel_n_s;
    end

    // Link state registers
    logic [7:0]   cfg_q [4];          // Configuration registers
    logic [7:0]   cfg_d [4];
    logic [7:0]   rx_q, rx_d;         // Incoming byte shifter
    logic [2:0]   bit_q, bit_d;       // Bit within byte
    pasq_dec_e    st_q, st_d;         // Decoder state
    logic [1:0]   reg_q, reg_d;       // Write pointer
    logic [1:0]   left_q, left_d;     // Bytes left minus one
    logic [15:0]  conv_q, conv_d;     // Conversion timer
    logic         conv_on_q, conv_on_d;
    logic [23:0]  tx_q, tx_d;         // Outgoing shifter
    logic         miso_q, miso_d;
    logic         oe_q, oe_d;
    logic         rdy_q, rdy_d;
    logic [7:0]   byte_in;
    logic         byte_done;
    // Buffer wiring
    pasq_result_s conv_res;
    logic         buf_in_ready, buf_out_valid, buf_pop;
    pasq_result_s buf_out;

    // Result word: temperature in top 14 bits, pressure full width
    always_comb begin
        conv_res.temp = cfg_q[1][PASQ_TSEL_BIT];
        if (cfg_q[1][PASQ_TSEL_BIT]) begin
            conv_res.code = {temp_sample, 10'h000};
        end else begin
            conv_res.code = pres_sample;
        end
    end

    // Results queue while the host is still shifting the previous one
    pasq_buf2 u_buf (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (conv_on_q && conv_q == 16'h0000),
        .in_ready  (buf_in_ready),
        .in_data   (conv_res),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out)
    );

    // Load a fresh result at a word boundary while deselected
    assign buf_pop = buf_out_valid && sel_n_s;

    // Next-state of command decode, config and shifter
    always_comb begin
        cfg_d     = cfg_q;
        rx_d      = rx_q;
        bit_d     = bit_q;
        st_d      = st_q;
        reg_d     = reg_q;
        left_d    = left_q;
        conv_d    = conv_q;
        conv_on_d = conv_on_q;
        tx_d      = tx_q;
        miso_d    = miso_q;
        oe_d      = !sel_n_s;
        rdy_d     = rdy_q;
        byte_in   = {rx_q[6:0], mosi_s};
        byte_done = fall && (bit_q == 3'h7);
        // Conversion timer; hold at zero until the queue takes the result
        if (conv_on_q) begin
            if (conv_q != 16'h0000) begin
                conv_d = conv_q - 16'h0001;
            end else if (buf_in_ready) begin
                conv_on_d = 1'b0;
            end
        end
        if (buf_pop) begin
            tx_d  = buf_out.code;
            rdy_d = 1'b1;
        end
        if (sel_n_s) begin
            bit_d = 3'h0;                                               // Frame end resyncs
            st_d  = PASQ_IDLE;
        end
        // Drive next bit on rising edge, mode 1
        if (rise) begin
            miso_d = tx_q[23];
            tx_d   = {tx_q[22:0], 1'b0};
            rdy_d  = 1'b0;
        end
        // Capture on falling edge, mode 1
        if (fall) begin
            rx_d  = byte_in;
            bit_d = bit_q + 3'h1;
        end
        // Byte-boundary decode, also during result reads
        if (byte_done) begin
            case (st_q)
                PASQ_IDLE: begin
                    if (byte_in == PASQ_CMD_RESET) begin
                        cfg_d[0] = PASQ_CFG0_RST;
                        cfg_d[1] = PASQ_CFG1_RST;
                        cfg_d[2] = PASQ_CFG2_RST;
                        cfg_d[3] = PASQ_CFG3_RST;
                    end else if (byte_in == PASQ_CMD_START) begin
                        conv_d    = 16'(PASQ_CONV_CYC);
                        conv_on_d = 1'b1;
                    end else if (byte_in[7:4] == PASQ_CMD_WR_HI) begin
                        reg_d  = byte_in[3:2];
                        left_d = byte_in[1:0];
                        st_d   = PASQ_WR_DATA;
                    end
                end
                PASQ_WR_DATA: begin
                    cfg_d[reg_q] = byte_in;
                    if (reg_q == 2'h1) begin
                        cfg_d[1][PASQ_ONE_BIT]  = 1'b1;
                        cfg_d[1][PASQ_ZERO_BIT] = 1'b0;
                    end
                    reg_d = reg_q + 2'h1;
                    if (left_q == 2'h0) begin
                        st_d = PASQ_IDLE;
                        if (reg_q == 2'h1) begin
                            conv_d    = 16'(PASQ_CONV_CYC);
                            conv_on_d = 1'b1;
                        end
                    end else begin
                        left_d = left_q - 2'h1;
                    end
                end
                default: st_d = PASQ_IDLE;
            endcase
        end
    end

    // Registering only
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q[0]  <= PASQ_CFG0_RST;
            cfg_q[1]  <= PASQ_CFG1_RST;
            cfg_q[2]  <= PASQ_CFG2_RST;
            cfg_q[3]  <= PASQ_CFG3_RST;
            rx_q      <= 8'h00;
            bit_q     <= 3'h0;
            st_q      <= PASQ_IDLE;
            reg_q     <= 2'h0;
            left_q    <= 2'h0;
            conv_q    <= 16'h0000;
            conv_on_q <= 1'b0;
            tx_q      <= 24'h000000;
            miso_q    <= 1'b0;
            oe_q      <= 1'b0;
            rdy_q     <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            rx_q      <= rx_d;
            bit_q     <= bit_d;
            st_q      <= st_d;
            reg_q     <= reg_d;
            left_q    <= left_d;
            conv_q    <= conv_d;
            conv_on_q <= conv_on_d;
            tx_q      <= tx_d;
            miso_q    <= miso_d;
            oe_q      <= oe_d;
            rdy_q     <= rdy_d;
        end
    end

    // Outputs straight from flip-flops
    assign miso         = miso_q;
    assign miso_oe      = oe_q;
    assign cfg0         = cfg_q[0];
    assign cfg1         = cfg_q[1];
    assign cfg2         = cfg_q[2];
    assign cfg3         = cfg_q[3];
    assign converting   = conv_on_q;
    assign result_ready = rdy_q;
endmodule // pasq_top
`default_nettype wire

// File: tb/pasq_checker.sv
// Purpose: port checks on pasq_top
// Assumes: one mclk domain, rst synchronous active high
// Notes:   bound to every pasq_top at the file foot
`default_nettype none
module pasq_checker
    import pasq_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Link pins
    input wire logic       sclk,
    input wire logic       adc_select_n,
    input wire logic       miso,
    input wire logic       miso_oe,
    // Configuration and status
    input wire logic [7:0] cfg0,
    input wire logic [7:0] cfg1,
    input wire logic [7:0] cfg2,
    input wire logic [7:0] cfg3,
    input wire logic       converting,
    input wire logic       result_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [15:0] run_q;  // Cycles of the current conversion
    logic [15:0] run_d;  // Next run length
    // Count while converting
    always_comb begin
        run_d = converting ? run_q + 16'h1 : 16'h0;
    end
    // Run length register
    always_ff @(posedge mclk) begin
        run_q <= rst ? 16'h0 : run_d;
    end
    property p_rst_cfg;
        $fell(rst) |-> {cfg0, cfg1, cfg2, cfg3} === {PASQ_CFG0_RST, PASQ_CFG1_RST,
            PASQ_CFG2_RST, PASQ_CFG3_RST} && !converting && !result_ready;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("config not at defaults");
    property p_fixed;
        cfg1[PASQ_ONE_BIT] && !cfg1[PASQ_ZERO_BIT];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
    property p_oe_on;
        (!adc_select_n)[*6] |-> miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not driven");
    property p_oe_off;
        adc_select_n[*6] |-> !miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven unselected");
    property p_miso_hold;
        $fell(sclk) && !adc_select_n |-> ##2 $stable(miso)[*2];
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("data moved in low phase");
    property p_cfg_quiet;
        adc_select_n[*8] |-> $stable({cfg0, cfg1, cfg2, cfg3});
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("config moved unselected");
    property p_conv_len;
        $fell(converting) |-> run_q >= 16'(PASQ_CONV_CYC - 2);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion too short");
    property p_ready_load;
        $fell(converting) && adc_select_n |-> ##[0:8] result_ready;
    endproperty
    a_ready_load: assert property (p_ready_load) else $error("result not loaded");
    property p_ready_clr;
        result_ready && $rose(sclk) |-> ##[1:6] !result_ready;
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");
    // Main scenarios reached
    c_conv: cover property ($rose(converting));
    c_ready: cover property ($rose(result_ready));
    c_midread: cover property (!adc_select_n && converting && $rose(sclk));
endmodule // pasq_checker
bind pasq_top pasq_checker u_chk (.mclk(mclk), .rst(rst), .sclk(sclk),
    .adc_select_n(adc_select_n), .miso(miso), .miso_oe(miso_oe), .cfg0(cfg0),
    .cfg1(cfg1), .cfg2(cfg2), .cfg3(cfg3), .converting(converting),
    .result_ready(result_ready));
`default_nettype wire

// File: tb/pasq_host.sv
// Purpose: host SPI controller model
// Assumes: link clock 800 ns, four mclk per half period
// Notes:   link clock stands low outside frames
`default_nettype none
module pasq_host (
    // Clock
    input  wire logic mclk,
    // Link pins
    input  wire logic miso,
    output var  logic sclk,
    output var  logic adc_select_n,
    output var  logic mosi,
    output var  logic calib_memory_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels
    initial begin
        sclk = 1'b0;
        adc_select_n = 1'b1;
        mosi = 1'b0;
        calib_memory_select_n = 1'b1;
    end
    // Half a link clock period
    task automatic half();
        repeat (4) @(posedge mclk);
        #10;
    endtask
    // Memory off first, then converter on
    task automatic sel_on();
        calib_memory_select_n = 1'b1;
        @(posedge mclk);
        #10;
        adc_select_n = 1'b0;
        half();
    endtask
    // Release; data line shows the inverse once released
    task automatic sel_off();
        half();
        adc_select_n = 1'b1;
        mosi = ~mosi;
        half();
    endtask
    // One byte, MSB first, mode 1
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            half();
            rx[i] = miso;
            sclk = 1'b0;
            half();
        end
    endtask
endmodule // pasq_host
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for pasq_top
// Assumes: mclk 100 ns, host model drives the link
// Notes:   one task per scenario
`default_nettype none
module tb_top
    import pasq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst, sclk, adc_select_n, mosi, miso, miso_oe, cal_n;
    logic        converting, result_ready;
    logic [13:0] temp_sample;
    logic [23:0] pres_sample;
    logic [7:0]  cfg0, cfg1, cfg2, cfg3;
    int          err_total, tests_run;
    // Device under test
    pasq_top u_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .adc_select_n(adc_select_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .temp_sample(temp_sample),
        .pres_sample(pres_sample), .cfg0(cfg0), .cfg1(cfg1), .cfg2(cfg2), .cfg3(cfg3),
        .converting(converting), .result_ready(result_ready));
    // Host side
    pasq_host u_host (.mclk(mclk), .miso(miso), .sclk(sclk), .adc_select_n(adc_select_n),
        .mosi(mosi), .calib_memory_select_n(cal_n));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // Bounded wait for a loaded result
    task automatic wait_ready();
        for (int n = 0; n < 600 && result_ready !== 1'b1; n++) @(posedge mclk);
        #10;
        chk(result_ready === 1'b1, "no result");
        if (result_ready !== 1'b1) complete_run();
    endtask
    // Three-byte frame
    task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
        u_host.sel_on();
        u_host.xbyte(tx[23:16], rx[23:16]);
        u_host.xbyte(tx[15:8], rx[15:8]);
        u_host.xbyte(tx[7:0], rx[7:0]);
        u_host.sel_off();
    endtask
    function automatic logic is_dflt();
        return {cfg0, cfg1, cfg2, cfg3} ===
            {PASQ_CFG0_RST, PASQ_CFG1_RST, PASQ_CFG2_RST, PASQ_CFG3_RST};
    endfunction
    task automatic t_power_up();
        logic [7:0] rx;
        chk(is_dflt() && miso_oe === 1'b0, "reset state");
        u_host.sel_on();
        u_host.xbyte(PASQ_CMD_RESET, rx);
        u_host.xbyte(8'h43, rx);
        u_host.xbyte(8'h0a, rx);
        u_host.xbyte(8'h84, rx);
        u_host.xbyte(8'h40, rx);
        u_host.xbyte(8'h00, rx);
        u_host.sel_off();
        chk({cfg0, cfg1, cfg2, cfg3} === 32'h0a844000, "init write");
        u_host.sel_on();
        u_host.xbyte(PASQ_CMD_RESET, rx);
        u_host.sel_off();
        chk(is_dflt(), "reset command");
        $display("test power_up done");
    endtask
    task automatic t_temp();
        logic [23:0] rx;
        frame(24'h440600, rx);
        chk(cfg1 === 8'h06, "temperature mode");
        wait_ready();
        u_host.sel_on();
        chk(miso_oe === 1'b1, "output not enabled");
        u_host.xbyte(PASQ_CMD_START, rx[23:16]);
        temp_sample = 14'h0960;
        u_host.xbyte(8'h00, rx[15:8]);
        chk(converting === 1'b1, "no conversion");
        u_host.xbyte(8'h00, rx[7:0]);
        u_host.sel_off();
        chk(rx[23:10] === 14'h3ce0, "negative temperature");
        chk($itor($signed(rx[23:10])) * 0.03125 == -25.0, "temperature scale");
        wait_ready();
        $display("test temp done");
    endtask
    task automatic t_pres();
        logic [23:0] rx;
        frame(24'h440100, rx);
        chk(rx[23:10] === 14'h0960, "temperature under write");
        chk(cfg1 === 8'h04, "pressure mode");
        wait_ready();
        frame(24'h000000, rx);
        chk(rx === pres_sample, "pressure code");
        chk(cfg1 === 8'h04, "padding ignored");
        $display("test pres done");
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        temp_sample = 14'h3ce0;
        pres_sample = 24'h800001;
        err_total = 0;
        tests_run = 0;
        repeat (3) @(posedge mclk);
        #10 rst = 1'b0;
        repeat (3) @(posedge mclk);
        t_power_up();
        t_temp();
        t_pres();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
